// file: ccv_checksum_verifier.sv
// Configuration checksum verifier: reads the non-volatile image, recomputes its CRC and flags a mismatch.
// Assumes a synchronous image read port with one cycle of latency and a register strobe port from the
// serial interface decoder.
//
// Overview of operation
// (RULE1) CRC-8, polynomial x8+x6+x3+x2+1, constant 4d.
// (RULE2) XOR byte, shift eight times, conditional feedback.
// (RULE3) Cover image bytes 0 to 33, ascending.
// (RULE4) Start CRC from the per-part seed value.
// (RULE5) Device computes CRC, shows it at 010e.
// (RULE6) Mismatch with stored byte sets error flag.
// (RULE7) Periodic reverify while motor runs, when enabled.
// (RULE8) Mode bit chooses keep running or stop.
// (RULE9) Whole diagnostic gated by feature enable bit.
// (RULE10) Reload working mode bits at reset, download.
// (RULE11) Software writes the stored checksum byte.
// (RULE12) Software sets mode bits before programming.
// (RULE13) Software reads each part's seed first.
// (RULE14) Copy image at startup, busy meanwhile.
// (RULE15) Feature off: never flag, never stop.
`default_nettype none
`include "ccv_cfg.svh"

module ccv_checksum_verifier
    import ccv_pkg::*;
#(
    parameter int PERIOD_CYCLES = `CCV_PERIOD_CYCLES
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Register access from the serial interface decoder.
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    // Non-volatile image read port, data valid one cycle after the address.
    output var  logic [5:0]  image_addr,
    input  wire logic [7:0]  image_rdata,
    // Per-part seed from the reserved fuse area.
    input  wire logic [7:0]  checksum_seed_value,
    // Download and motor side.
    input  wire logic        download_command,
    input  wire logic        motor_running,
    output var  logic        nonvolatile_busy_flag,
    output var  logic        motor_stop_request
);

    localparam int TIMER_W = $clog2(PERIOD_CYCLES + 1);

    // All state lives in one record. The read-back copies of the non-volatile bytes are refreshed on every
    // pass, load or periodic. The working mode copy is refreshed only by a load. A value that software wrote
    // into the working copy therefore survives periodic verification and is lost only at the next download
    // or reset.
    typedef struct packed {
        ccv_state_t         state;
        logic [5:0]         addr;
        logic               rd_valid;
        logic [5:0]         rd_idx;
        logic               loading;
        logic [7:0]         mode_working;
        logic [7:0]         mode_nv;
        logic [7:0]         lock_check;
        logic [7:0]         stored;
        logic [7:0]         calculated;
        logic               error_flag;
        logic [TIMER_W-1:0] timer;
        logic [7:0]         rdata;
    } ccv_top_state_t;

    ccv_top_state_t cur;
    ccv_top_state_t next_cur;
    logic           feature_en;
    logic           periodic_en;

    ccv_crc_if crc_bus ();

    ccv_crc_engine u_crc (
        .clock   (clock),
        .sys_rst (sys_rst),
        .crc_bus (crc_bus.engine)
    );

    // Feature and mode bits come from the loaded image and working copy.
    // A pass that reads the feature enable bit as zero silences the diagnostic until a later pass reads a one.
    assign feature_en  = cur.lock_check[`CCV_BIT_FEATURE_EN];                     // see (RULE9)
    assign periodic_en = cur.mode_working[`CCV_BIT_PERIODIC_EN];

    // Feed image bytes into the engine as they return; the stored byte is kept out of the sum.
    // The seed is loaded while the first address of a pass is out, so byte 0 folds onto it one cycle later.
    // Keying this on the first cycle of a pass, not on leaving idle, also covers the load that reset starts.
    assign crc_bus.init       = (cur.state == CCV_READ) && (cur.addr == 6'd0);    // see (RULE4)
    assign crc_bus.seed       = checksum_seed_value;                              // see (RULE4)
    assign crc_bus.byte_valid = cur.rd_valid && (cur.rd_idx < `CCV_IMAGE_COVERED); // see (RULE3)
    assign crc_bus.data       = image_rdata;

    // Sequencer, register file and periodic timer.
    // A pass walks the image addresses 0 to 34 once. The engine folds the bytes as they come back, and the
    // check state compares the result with the stored byte. A load pass also refreshes the working mode copy
    // and raises the busy flag; a periodic pass does neither. The timer counts only in idle, so the interval
    // runs from the end of one pass to the start of the next.
    always_comb begin
        logic mismatch;
        mismatch = 1'b0;
        next_cur = cur;
        next_cur.rd_valid = 1'b0;
        unique case (cur.state)
            CCV_IDLE: begin
                // A download always wins over a periodic pass that would start in the same cycle.
                if (download_command) begin
                    next_cur.state   = CCV_READ;
                    next_cur.loading = 1'b1;
                    next_cur.addr    = 6'd0;
                    next_cur.timer   = '0;                                        // Restart the interval.
                end else if (feature_en && periodic_en && motor_running) begin // see (RULE7)
                    if (cur.timer >= TIMER_W'(PERIOD_CYCLES - 1)) begin
                        next_cur.timer = '0;
                        next_cur.state = CCV_READ;
                        next_cur.addr  = 6'd0;
                    end else begin
                        next_cur.timer = cur.timer + TIMER_W'(1);
                    end
                end else begin
                    next_cur.timer = '0;
                end
            end
            CCV_READ: begin
                // Addresses run 0 to 34 in ascending order; data trails by one cycle.
                next_cur.rd_valid = 1'b1;
                next_cur.rd_idx   = cur.addr;
                if (cur.addr == `CCV_IDX_STORED) begin
                    next_cur.state = CCV_CHECK;
                end else begin
                    next_cur.addr = cur.addr + 6'd1;
                end
            end
            CCV_CHECK: begin
                // The last byte is folded on entry here, so the engine holds the final sum now.
                next_cur.calculated = crc_bus.crc;                                // see (RULE5)
                // The stored byte is on the read port in this very cycle and reaches its register only at
                // the end of it. The comparison therefore takes it from the port, because the register
                // still holds the byte of the previous pass.
                mismatch            = crc_bus.crc != image_rdata;                 // see (RULE6)
                if (mismatch && feature_en) begin                                 // see (RULE15)
                    next_cur.error_flag = 1'b1;                                   // see (RULE6)
                end
                next_cur.loading = 1'b0;
                next_cur.state   = CCV_IDLE;
            end
            default: begin
                // The unused code can only come from an upset. Drop back to idle, so that the next
                // download or periodic pass starts clean.
                next_cur.loading = 1'b0;
                next_cur.state   = CCV_IDLE;
            end
        endcase
        // Capture bytes of interest as they return from the image.
        // Each byte is taken straight off the read port, one cycle after its address went out.
        if (cur.rd_valid) begin
            if (cur.rd_idx == `CCV_IDX_MODE) begin
                next_cur.mode_nv = image_rdata;
                if (cur.loading) begin
                    next_cur.mode_working = image_rdata;                          // see (RULE10)
                end
            end
            if (cur.rd_idx == `CCV_IDX_LOCK_CHECK) begin
                next_cur.lock_check = image_rdata;
            end
            if (cur.rd_idx == `CCV_IDX_STORED) begin
                next_cur.stored = image_rdata;
            end
        end
        // Software may rewrite the working mode copy; the non-volatile registers are not written here.
        // Writes elsewhere are dropped, because the non-volatile bytes belong to the one-time programming flow.
        if (reg_wr && (reg_addr == `CCV_ADDR_MODE_WORKING) && !cur.loading) begin
            next_cur.mode_working = reg_wdata;
        end
        // Reading the diagnostic register clears the flag, unless a new error lands in the same cycle.
        // Such a read returns the old flag and leaves the new one standing for the next read.
        if (reg_rd && (reg_addr == `CCV_ADDR_DIAG_ONE) && !(mismatch && feature_en)) begin
            next_cur.error_flag = 1'b0;
        end
        // Read data is registered; unmapped addresses return zero.
        if (reg_rd) begin
            unique case (reg_addr)
                `CCV_ADDR_MODE_WORKING: next_cur.rdata = cur.mode_working;
                `CCV_ADDR_CALCULATED:   next_cur.rdata = cur.calculated;
                `CCV_ADDR_DIAG_ONE:     next_cur.rdata = {7'h00, cur.error_flag};
                `CCV_ADDR_SEED:         next_cur.rdata = checksum_seed_value;
                `CCV_ADDR_MODE_NV:      next_cur.rdata = cur.mode_nv;
                `CCV_ADDR_LOCK_CHECK:   next_cur.rdata = cur.lock_check;
                `CCV_ADDR_STORED:       next_cur.rdata = cur.stored;
                default:                next_cur.rdata = 8'h00;
            endcase
        end
    end

    // Reset starts a full image load, as a sleep to standby transition does.
    // Limitation: this load takes a few dozen cycles, far less than the slow fuse read that it stands for.
    // Software that polls the busy flag therefore sees it drop much sooner than it would on silicon.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cur              <= '0;
            cur.state        <= CCV_READ;                                         // see (RULE14)
            cur.loading      <= 1'b1;                                             // see (RULE10)
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs. The stop request is a level built only from flip-flops. It rises in the cycle after the check
    // that finds a mismatch, and it falls when a read of the diagnostic register clears the flag or when
    // software turns the stop action off.
    assign reg_rdata             = cur.rdata;
    assign image_addr            = cur.addr;
    assign nonvolatile_busy_flag = cur.loading;                                   // see (RULE14)
    assign motor_stop_request    = feature_en && cur.error_flag
                                   && cur.mode_working[`CCV_BIT_ACTION_STOP];     // see (RULE8)

endmodule : ccv_checksum_verifier

`default_nettype wire

// file: ccv_cfg.svh
// Constants of the configuration checksum verifier: register offsets, field positions, reset values, timing.
// Assumes a 16-bit register address space and 8-bit register data.
`ifndef CCV_CFG_SVH
`define CCV_CFG_SVH

// Register offsets.
`define CCV_ADDR_MODE_WORKING   16'h010a
`define CCV_ADDR_CALCULATED     16'h010e
`define CCV_ADDR_DIAG_ONE       16'h0202
`define CCV_ADDR_SEED           16'h0208
`define CCV_ADDR_MODE_NV        16'h100a
`define CCV_ADDR_LOCK_CHECK     16'h1021
`define CCV_ADDR_STORED         16'h1022

// Image byte indices inside the non-volatile configuration.
`define CCV_IDX_MODE            6'd10
`define CCV_IDX_LOCK_CHECK      6'd33
`define CCV_IDX_STORED          6'd34
`define CCV_IMAGE_COVERED       6'd34

// Field positions.
`define CCV_BIT_PERIODIC_EN     0
`define CCV_BIT_ACTION_STOP     1
`define CCV_BIT_FEATURE_EN      2
`define CCV_BIT_ERROR_FLAG      0

// CRC feedback constant and the bit that leaves the register.
`define CCV_CRC_POLY            8'h4d
`define CCV_CRC_TOPBIT          8'h80

// Reset values.
`define CCV_RST_BYTE            8'h00

// Periodic verify interval, in microseconds, and the clock rate in MHz.
`define CCV_PERIOD_US           1000
`define CCV_CLOCK_MHZ           250
`define CCV_PERIOD_CYCLES       (`CCV_PERIOD_US * `CCV_CLOCK_MHZ)

`endif

// file: ccv_pkg.sv
// Types shared by the configuration checksum verifier modules.
// Assumes nothing of its surroundings.
`default_nettype none

package ccv_pkg;

    // Sequencer states, Gray coded along idle, read, check.
    typedef enum logic [1:0] {
        CCV_IDLE  = 2'b00,
        CCV_READ  = 2'b01,
        CCV_CHECK = 2'b11
    } ccv_state_t;

endpackage : ccv_pkg

`default_nettype wire

// file: ccv_crc_if.sv
// Carrier between the checksum sequencer and the CRC engine.
// Assumes both ends sit on the same clock.
`default_nettype none

interface ccv_crc_if;
    logic       init;
    logic [7:0] seed;
    logic       byte_valid;
    logic [7:0] data;
    logic [7:0] crc;

    modport sequencer (output init, output seed, output byte_valid, output data, input crc);
    modport engine    (input init, input seed, input byte_valid, input data, output crc);
endinterface : ccv_crc_if

`default_nettype wire

// file: ccv_crc_engine.sv
// CRC-8 engine that folds one configuration byte per clock into its register.
// Assumes the sequencer pulses init before the first byte of every pass.
`default_nettype none
`include "ccv_cfg.svh"

module ccv_crc_engine
    import ccv_pkg::*;
(
    // Clock and reset.
    input  wire logic   clock,
    input  wire logic   sys_rst,
    // Sequencer side.
    ccv_crc_if.engine   crc_bus
);

    typedef struct packed {
        logic [7:0] crc;
    } ccv_crc_state_t;

    ccv_crc_state_t cur;
    ccv_crc_state_t next_cur;

    // Eight bitwise steps unrolled by a loop so one byte costs one cycle.
    function automatic logic [7:0] ccv_crc8_byte(input logic [7:0] crc_in, input logic [7:0] data_in);
        logic [7:0] acc;
        acc = crc_in ^ data_in;                                     // see (RULE2)
        for (int i = 0; i < 8; i++) begin
            if ((acc & `CCV_CRC_TOPBIT) != 8'h00) begin
                acc = {acc[6:0], 1'b0} ^ `CCV_CRC_POLY;             // see (RULE1)
            end else begin
                acc = {acc[6:0], 1'b0};
            end
        end
        return acc;
    endfunction : ccv_crc8_byte

    // Seed load takes priority over a byte in the same cycle.
    always_comb begin
        next_cur = cur;
        if (crc_bus.init) begin
            next_cur.crc = crc_bus.seed;                            // see (RULE4)
        end else if (crc_bus.byte_valid) begin
            next_cur.crc = ccv_crc8_byte(cur.crc, crc_bus.data);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cur <= '{crc: `CCV_RST_BYTE};
        end else begin
            cur <= next_cur;
        end
    end

    assign crc_bus.crc = cur.crc;

endmodule : ccv_crc_engine

`default_nettype wire

// file: ccv_props.sv
// Port checker of the configuration checksum verifier.
// Assumes it is bound into every instance of ccv_checksum_verifier on one clock.
`default_nettype none

module ccv_props #(
    parameter int PERIOD_CYCLES = 50
) (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        sys_rst,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Image, seed and motor side.
    input wire logic [5:0]  image_addr,
    input wire logic [7:0]  checksum_seed_value,
    input wire logic        download_command,
    input wire logic        motor_running,
    input wire logic        nonvolatile_busy_flag,
    input wire logic        motor_stop_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Only the seven mapped offsets may return data.
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {16'h010a, 16'h010e, 16'h0202, 16'h0208,
        16'h100a, 16'h1021, 16'h1022}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_seed_readback: assert property (reg_rd && reg_addr == 16'h0208 |=>
        reg_rdata == $past(checksum_seed_value)) else $error("seed readback wrong");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_load_after_reset: assert property ($fell(sys_rst) |-> ##[0:2] nonvolatile_busy_flag)
        else $error("no load after reset");
    a_pass_from_zero: assert property ($rose(nonvolatile_busy_flag) |-> image_addr == 6'd0)
        else $error("pass not from byte zero");
    a_addr_ascend: assert property (image_addr inside {[6'd1:6'd33]} |=>
        image_addr == $past(image_addr) + 6'd1) else $error("image address not ascending");
    a_busy_span: assert property ($rose(nonvolatile_busy_flag) |-> nonvolatile_busy_flag[*8]
        ##[22:32] !nonvolatile_busy_flag) else $error("busy span wrong");
    // A periodic pass still runs until the address has stood at 34 for two cycles, and a download is ignored then.
    a_download_load: assert property (download_command && !nonvolatile_busy_flag && image_addr == 6'd34
        && $past(image_addr, 2) == 6'd34 |=> nonvolatile_busy_flag) else $error("download ignored");
    a_stop_has_flag: assert property (motor_stop_request && reg_rd && reg_addr == 16'h0202
        |=> reg_rdata == 8'h01) else $error("stop without error flag");

    // Main scenarios reached.
    c_stop: cover property ($rose(motor_stop_request));
    c_load: cover property ($rose(nonvolatile_busy_flag));
    c_periodic: cover property (motor_running && image_addr == 6'd0 && !nonvolatile_busy_flag);
endmodule : ccv_props

bind ccv_checksum_verifier ccv_props #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_props (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .image_addr(image_addr),
    .checksum_seed_value(checksum_seed_value), .download_command(download_command), .motor_running(motor_running),
    .nonvolatile_busy_flag(nonvolatile_busy_flag), .motor_stop_request(motor_stop_request));

`default_nettype wire

// file: ccv_checksum_verifier_tb_top.sv
// Self-checking bench of the checksum verifier: register accesses against a modelled image.
// Assumes the design files and the checker are compiled before it.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module ccv_checksum_verifier_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD = 50;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [5:0]  image_addr;
    logic [7:0]  image_rdata = 8'h00;
    logic [7:0]  seed = 8'h5a;
    logic        download_command = 1'b0;
    logic        motor_running = 1'b0;
    logic        nonvolatile_busy_flag;
    logic        motor_stop_request;
    logic [7:0]  mem [35];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    ccv_checksum_verifier #(.PERIOD_CYCLES(PERIOD)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .image_addr(image_addr),
        .image_rdata(image_rdata), .checksum_seed_value(seed), .download_command(download_command),
        .motor_running(motor_running), .nonvolatile_busy_flag(nonvolatile_busy_flag),
        .motor_stop_request(motor_stop_request));

    // Clock of 4 ns; the image answers one cycle after its address, like the real read port.
    initial forever #2 clock = ~clock;
    always @(posedge clock) image_rdata <= mem[image_addr];

    // Reference CRC over bytes 0 to 33, kept apart from the design's engine.
    function automatic logic [7:0] crc_of(input logic [7:0] s);
        logic [7:0] c;
        c = s;
        for (int i = 0; i < 34; i++) begin
            c ^= mem[i];
            for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ 8'h4d) : (c << 1);
        end
        return c;
    endfunction : crc_of

    task automatic close_out();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd_chk

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Waits for the load to finish, giving up after 200 more cycles so a stuck busy cannot hang the sequence.
    task automatic wait_idle();
        repeat (3) @(posedge clock);
        for (int k = 0; k < 200 && nonvolatile_busy_flag !== 1'b0; k++) @(posedge clock);
    endtask : wait_idle

    task automatic download(input logic [7:0] mode, input logic [7:0] feat, input logic good);
        mem[10] = mode;
        mem[33] = feat;
        mem[34] = good ? crc_of(seed) : ~crc_of(seed);
        @(posedge clock);
        download_command <= 1'b1;
        @(posedge clock);
        download_command <= 1'b0;
        #1 `CHK(nonvolatile_busy_flag, 1'b1)
        wait_idle();
    endtask : download

    // A hang is cut short well above the few hundred cycles the sequence needs.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        for (int i = 0; i < 35; i++) mem[i] = 8'(i * 7 + 3);
        mem[10] = 8'h00;
        mem[33] = 8'h04;
        mem[34] = crc_of(seed);
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        wait_idle();
        rd_chk(16'h010e, crc_of(seed));
        rd_chk(16'h0202, 8'h00);
        rd_chk(16'h0208, seed);
        rd_chk(16'h0300, 8'h00);
        // Mismatch with the keep-running action, then the stop action written live.
        download(8'h00, 8'h04, 1'b0);
        rd_chk(16'h010e, crc_of(seed));
        `CHK(motor_stop_request, 1'b0)
        reg_write(16'h010a, 8'h02);
        `CHK(motor_stop_request, 1'b1)
        rd_chk(16'h0202, 8'h01);
        rd_chk(16'h0202, 8'h00);
        `CHK(motor_stop_request, 1'b0)
        // Feature off: a mismatch must stay silent, mode bits still reload.
        download(8'h03, 8'h00, 1'b0);
        rd_chk(16'h010a, 8'h03);
        rd_chk(16'h0202, 8'h00);
        `CHK(motor_stop_request, 1'b0)
        // Periodic reverify while the motor turns finds a mismatch again.
        download(8'h01, 8'h04, 1'b0);
        rd_chk(16'h0202, 8'h01);
        motor_running <= 1'b1;
        repeat (3 * PERIOD) @(posedge clock);
        rd_chk(16'h0202, 8'h01);
        `CHK(motor_stop_request, 1'b0)
        motor_running <= 1'b0;
        close_out();
    end
endmodule : ccv_checksum_verifier_tb_top

`default_nettype wire
